// ==== ulmc_core.sv ====
// ulmc_core: character format, modem control and line status of a serial port.
// assumes pins and register port synchronous to clk_i; irq pin resolved outside.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - two low format bits set 5..8 data bits
// - stop select gives 1, 1.5 or 2
// - receiver checks only first stop bit
// - parity enable adds bit after data
// - even select chooses even, else odd
// - stick parity forces bit to inverted even
// - break bit holds transmit line low outside loopback
// - divisor select steers shared offsets to divisor
// - modem bits 0,1 drive active-low pins inverted
// - general output one has no pin, feeds ri in loopback
// - interrupt gate enables irq driver
// - loopback: tx mark, pins inactive, internal loop
// - loopback maps control bits onto modem inputs
// - modem control bits 5..7 read zero
// - receive available until all data read
// - overrun on lost character, status read clears
// - parity error per character, status read clears
// - framing error, resync on low stop
// - break stores one zero, half-bit high restart
// - line errors raise line status interrupt
// - holding empty flag drives transmit interrupt
// - idle only when holding and shifter empty
// - fifo enable switches both fifos
// - bit 7 shows errors held in fifo
module ulmc_core
  import ulmc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      reset_i,
  input  wire ulmc_bus_t bus_i,
  output logic [7:0]     rdata_o,
  input  wire logic      rxd_i,
  output logic           txd_o,
  input  wire logic      clear_to_send_n_i,
  input  wire logic      data_set_ready_n_i,
  input  wire logic      ring_indicator_n_i,
  input  wire logic      carrier_detect_n_i,
  output logic           terminal_ready_n_o,
  output logic           request_to_send_n_o,
  output logic           irq_o,
  output logic           irq_oe_o
);
  ulmc_state_t   q;
  ulmc_state_t   d;
  logic          rx_in;
  logic          rx_pop;
  logic          rx_push;
  logic          clr_rx;
  logic          clr_tx;
  logic          ovr;
  logic          top_set;
  logic          e7;
  logic          tx_empty;
  logic          dsel;
  ulmc_rxent_t   rx_ent;
  ulmc_rxent_t   top_ent;
  logic [PW-1:0] rx_cnt;
  logic [PW-1:0] tx_cnt;
  logic [PW-1:0] cap;
  logic [7:0]    line_condition_flags;
  logic [7:0]    rx_al;
  logic [3:0]    mlvl;
  logic [3:0]    j;
  logic [2:0]    lastb;
  logic [5:0]    stop_t;

  always_comb begin
    d       = q;
    rx_pop  = 1'b0;
    rx_push = 1'b0;
    ovr     = 1'b0;
    top_set = 1'b0;
    top_ent = '0;
    clr_rx  = 1'b0;
    clr_tx  = 1'b0;
    rx_ent  = '0;
    e7      = 1'b0;
    j       = '0;
    dsel    = q.lfc[LF_DSEL];
    lastb   = ulmc_last(q.lfc);
    rx_cnt  = q.rxw - q.rxr;
    tx_cnt  = q.txw - q.txr;
    cap     = q.fen ? CAP_FIFO : CAP_ONE;
    tx_empty = (tx_cnt == '0);
    rx_al   = q.rxsh >> (3'h7 - lastb);
    rx_in   = q.moc[MC_LOOP] ? q.txbit : rxd_i;
    // stop length in ticks; 1.5 bits only for five-bit words
    stop_t  = !q.lfc[LF_STOP] ? T_STOP1 : (q.lfc[1:0] == 2'h0) ? T_STOP15 : T_STOP2;
    // cts, dsr, ri, dcd as seen by the status logic
    mlvl = q.moc[MC_LOOP] ? {q.moc[MC_IGATE], q.moc[MC_GOUT1], q.moc[MC_TRDY], q.moc[MC_RTS]}
                          : ~{carrier_detect_n_i, ring_indicator_n_i, data_set_ready_n_i, clear_to_send_n_i};
    for (int k = 0; k < DEPTH; k++) begin
      j = q.rxr[3:0] + 4'(k);
      if (PW'(k) < rx_cnt) e7 = e7 | q.rxm[j].brk | q.rxm[j].frm | q.rxm[j].par;
    end
    line_condition_flags = {q.fen & e7, tx_empty && q.txs == TX_IDLE, tx_empty, q.err, q.oe, rx_cnt != '0};

    // baud tick at sixteen times the bit rate
    d.tick = 1'b0;
    if (q.bcnt + 16'h0001 >= q.div) begin
      d.bcnt = '0;
      d.tick = 1'b1;
    end else begin
      d.bcnt = q.bcnt + 16'h0001;
    end

    d.rdata = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        A_DATA: begin
          d.rdata = dsel ? q.div[7:0] : q.rxm[q.rxr[3:0]].data;
          rx_pop  = !dsel && rx_cnt != '0;
        end
        A_IEN:        d.rdata = dsel ? q.div[15:8] : {4'h0, q.ien};
        A_LINE_FMT:   d.rdata = q.lfc;
        A_MODEM_CTL:  d.rdata = {3'h0, q.moc};
        A_LINE_FLAGS: d.rdata = line_condition_flags;
        A_MODEM_STAT: d.rdata = {q.mlvl, q.mdel};
        default:      d.rdata = '0;
      endcase
    end
    if (bus_i.wr) begin
      case (bus_i.addr)
        A_DATA: begin
          if (dsel) begin
            d.div[7:0] = bus_i.wdata;
            d.bcnt     = '0;
          end else if (tx_cnt < cap) begin
            d.txm[q.txw[3:0]] = bus_i.wdata;
            d.txw             = q.txw + 5'h01;
          end
        end
        A_IEN: begin
          if (dsel) begin
            d.div[15:8] = bus_i.wdata;
            d.bcnt      = '0;
          end else begin
            d.ien = bus_i.wdata[3:0];
          end
        end
        A_FIFO: begin
          d.fen  = bus_i.wdata[FS_EN];
          // a mode change flushes both sides
          clr_rx = bus_i.wdata[FS_RXCLR] || bus_i.wdata[FS_EN] != q.fen;
          clr_tx = bus_i.wdata[FS_TXCLR] || bus_i.wdata[FS_EN] != q.fen;
        end
        A_LINE_FMT:  d.lfc = bus_i.wdata;
        A_MODEM_CTL: d.moc = bus_i.wdata[4:0];
        default: ;
      endcase
    end

    // transmitter
    if (q.txs == TX_IDLE) begin
      if (!tx_empty) begin
        d.txsh  = q.txm[q.txr[3:0]];
        d.txr   = q.txr + 5'h01;
        d.txpar = ulmc_par(q.lfc, q.txm[q.txr[3:0]]);
        d.txs   = TX_START;
        d.txt   = '0;
        d.txbit = 1'b0;
      end
    end else if (q.tick) begin
      if (q.txt != ((q.txs == TX_STOP) ? stop_t : T_BIT)) begin
        d.txt = q.txt + 6'h01;
      end else begin
        d.txt = '0;
        unique case (q.txs)
          TX_START: begin
            d.txs   = TX_DATA;
            d.txn   = '0;
            d.txbit = q.txsh[0];
          end
          TX_DATA: begin
            if (q.txn == lastb) begin
              d.txs   = q.lfc[LF_PEN] ? TX_PAR : TX_STOP;
              d.txbit = q.lfc[LF_PEN] ? q.txpar : 1'b1;
            end else begin
              d.txn   = q.txn + 3'h1;
              d.txsh  = q.txsh >> 1;
              d.txbit = q.txsh[1];
            end
          end
          TX_PAR: begin
            d.txs   = TX_STOP;
            d.txbit = 1'b1;
          end
          TX_STOP: d.txs = TX_IDLE;
          TX_IDLE: ;
        endcase
      end
    end

    // receiver, sampled at bit centres
    if (q.tick) begin
      unique case (q.rxs)
        RX_IDLE: begin
          if (!rx_in) begin
            d.rxs = RX_START;
            d.rxt = '0;
          end
        end
        RX_START: begin
          d.rxt = q.rxt + 4'h1;
          if (q.rxt == T_MID) begin
            d.rxs    = rx_in ? RX_IDLE : RX_DATA;
            d.rxt    = '0;
            d.rxn    = '0;
            d.rxz    = 1'b1;
            d.rxperr = 1'b0;
          end
        end
        RX_DATA: begin
          d.rxt = q.rxt + 4'h1;
          if (q.rxt == T_LAST) begin
            d.rxsh = {rx_in, q.rxsh[7:1]};
            d.rxz  = q.rxz & ~rx_in;
            d.rxn  = q.rxn + 3'h1;
            if (q.rxn == lastb) d.rxs = q.lfc[LF_PEN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          d.rxt = q.rxt + 4'h1;
          if (q.rxt == T_LAST) begin
            d.rxperr = rx_in != ulmc_par(q.lfc, rx_al);
            d.rxz    = q.rxz & ~rx_in;
            d.rxs    = RX_STOP;
          end
        end
        RX_STOP: begin
          d.rxt = q.rxt + 4'h1;
          if (q.rxt == T_LAST) begin
            // only the first stop bit is looked at
            rx_push     = 1'b1;
            rx_ent.data = rx_al;
            rx_ent.par  = q.rxperr;
            rx_ent.frm  = ~rx_in;
            rx_ent.brk  = ~rx_in & q.rxz;
            if (rx_in) begin
              d.rxs = RX_IDLE;
            end else if (q.rxz) begin
              d.rxs = RX_BRK;
              d.rxt = '0;
            end else begin
              // take the low stop bit as the next start bit
              d.rxs = RX_DATA;
              d.rxt = '0;
              d.rxn = '0;
              d.rxz = 1'b1;
            end
          end
        end
        RX_BRK: begin
          d.rxt = rx_in ? q.rxt + 4'h1 : 4'h0;
          if (rx_in && q.rxt == T_MID) d.rxs = RX_IDLE;
        end
      endcase
    end

    // receive queue; a single entry when fifos are off
    if (rx_pop) begin
      d.rxr = q.rxr + 5'h01;
      if (rx_cnt > 5'h01) begin
        top_set = 1'b1;
        top_ent = q.rxm[q.rxr[3:0] + 4'h1];
      end
    end
    if (rx_push) begin
      if (rx_cnt == cap && !rx_pop) begin
        ovr = 1'b1;
        if (!q.fen) begin
          // without fifo the unread character is destroyed
          d.rxm[q.rxr[3:0]] = rx_ent;
          top_set = 1'b1;
          top_ent = rx_ent;
        end
      end else begin
        d.rxm[q.rxw[3:0]] = rx_ent;
        d.rxw             = q.rxw + 5'h01;
        if (rx_cnt == '0 || (rx_pop && rx_cnt == 5'h01)) begin
          top_set = 1'b1;
          top_ent = rx_ent;
        end
      end
    end
    if (clr_rx) d.rxr = d.rxw;
    if (clr_tx) d.txr = d.txw;

    // sticky flags: a new event beats the clearing status read
    d.oe  = (bus_i.rd && bus_i.addr == A_LINE_FLAGS ? 1'b0 : q.oe) | ovr;
    d.err = (bus_i.rd && bus_i.addr == A_LINE_FLAGS ? 3'h0 : q.err)
          | (top_set ? {top_ent.brk, top_ent.frm, top_ent.par} : 3'h0);
    d.mlvl = mlvl;
    d.mdel = (bus_i.rd && bus_i.addr == A_MODEM_STAT ? 4'h0 : q.mdel)
           | {mlvl[3] ^ q.mlvl[3], q.mlvl[2] & ~mlvl[2], mlvl[1:0] ^ q.mlvl[1:0]};

    // pins
    d.txd    = q.moc[MC_LOOP] | (~q.lfc[LF_BRK] & q.txbit);
    d.trdy_n = ~(q.moc[MC_TRDY] & ~q.moc[MC_LOOP]);
    d.rts_n  = ~(q.moc[MC_RTS] & ~q.moc[MC_LOOP]);
    d.irq    = |(q.ien & {|q.mdel, q.oe | (|q.err), tx_empty, rx_cnt != '0});
    d.irq_oe = q.moc[MC_IGATE];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q        <= '0;
      q.div    <= DIV_RST;
      q.txbit  <= 1'b1;
      q.txd    <= 1'b1;
      q.trdy_n <= 1'b1;
      q.rts_n  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata_o             = q.rdata;
  assign txd_o               = q.txd;
  assign terminal_ready_n_o  = q.trdy_n;
  assign request_to_send_n_o = q.rts_n;
  assign irq_o               = q.irq;
  assign irq_oe_o            = q.irq_oe;

  sequence s_trdy_on;
    bus_i.wr && bus_i.addr == A_MODEM_CTL && bus_i.wdata[MC_TRDY] && !bus_i.wdata[MC_LOOP];
  endsequence
  sequence s_rts_off;
    bus_i.wr && bus_i.addr == A_MODEM_CTL && !bus_i.wdata[MC_RTS];
  endsequence
  sequence s_stop_high;
    q.rxs == RX_STOP && q.tick && q.rxt == T_LAST && rx_in;
  endsequence

  property p_trdy;
    @(posedge clk_i) disable iff (reset_i) s_trdy_on |-> ##2 !terminal_ready_n_o;
  endproperty
  a_trdy: assert property (p_trdy) else $error("terminal ready not driven low");
  property p_rts;
    @(posedge clk_i) disable iff (reset_i) s_rts_off |-> ##2 request_to_send_n_o;
  endproperty
  a_rts: assert property (p_rts) else $error("request to send not released");
  property p_brk;
    @(posedge clk_i) disable iff (reset_i) q.lfc[LF_BRK] && !q.moc[MC_LOOP] |=> !txd_o;
  endproperty
  a_brk: assert property (p_brk) else $error("break not holding line low");
  property p_loop;
    @(posedge clk_i) disable iff (reset_i)
      q.moc[MC_LOOP] |=> txd_o && request_to_send_n_o && terminal_ready_n_o;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback pins not inactive");
  property p_moc_hi;
    @(posedge clk_i) disable iff (reset_i) bus_i.rd && bus_i.addr == A_MODEM_CTL |=> rdata_o[7:5] == 3'h0;
  endproperty
  a_moc_hi: assert property (p_moc_hi) else $error("modem control high bits not zero");
  property p_ovr;
    @(posedge clk_i) disable iff (reset_i) rx_push && rx_cnt == cap && !rx_pop |=> q.oe;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  property p_idle;
    @(posedge clk_i) disable iff (reset_i) bus_i.rd && bus_i.addr == A_LINE_FLAGS |=> !(rdata_o[6] && !rdata_o[5]);
  endproperty
  a_idle: assert property (p_idle) else $error("idle shown with holding full");
  property p_dsel;
    @(posedge clk_i) disable iff (reset_i) bus_i.wr && bus_i.addr == A_DATA && q.lfc[LF_DSEL]
      |=> q.div[7:0] == $past(bus_i.wdata) && q.txw == $past(q.txw);
  endproperty
  a_dsel: assert property (p_dsel) else $error("divisor write reached transmit path");
  property p_gate;
    @(posedge clk_i) disable iff (reset_i)
      bus_i.wr && bus_i.addr == A_MODEM_CTL && !bus_i.wdata[MC_IGATE] |-> ##2 !irq_oe_o;
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt driver not disabled");
  property p_avail;
    @(posedge clk_i) disable iff (reset_i) rx_push && !clr_rx |=> q.rxw != q.rxr;
  endproperty
  a_avail: assert property (p_avail) else $error("received character not available");
  property p_stop;
    @(posedge clk_i) disable iff (reset_i) s_stop_high |=> q.rxs == RX_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("receiver waited past first stop bit");
endmodule : ulmc_core
`default_nettype wire

// ==== ulmc_pkg.sv ====
// ulmc_pkg: constants, carriers and helpers for the serial line format block.
// assumes one 25 MHz clock and a plain register port.
package ulmc_pkg;
  localparam logic [2:0] A_DATA        = 3'h0;
  localparam logic [2:0] A_IEN         = 3'h1;
  localparam logic [2:0] A_FIFO        = 3'h2;
  localparam logic [2:0] A_LINE_FMT    = 3'h3;
  localparam logic [2:0] A_MODEM_CTL   = 3'h4;
  localparam logic [2:0] A_LINE_FLAGS  = 3'h5;
  localparam logic [2:0] A_MODEM_STAT  = 3'h6;
  // line_format_control fields
  localparam int LF_STOP  = 2;
  localparam int LF_PEN   = 3;
  localparam int LF_EVEN  = 4;
  localparam int LF_STICK = 5;
  localparam int LF_BRK   = 6;
  localparam int LF_DSEL  = 7;
  // modem_output_control fields
  localparam int MC_TRDY  = 0;
  localparam int MC_RTS   = 1;
  localparam int MC_GOUT1 = 2;
  localparam int MC_IGATE = 3;
  localparam int MC_LOOP  = 4;
  // fifo_setup_register fields
  localparam int FS_EN    = 0;
  localparam int FS_RXCLR = 1;
  localparam int FS_TXCLR = 2;
  localparam int DEPTH    = 16;
  localparam int PW       = 5;
  localparam logic [PW-1:0] CAP_FIFO = 5'h10;
  localparam logic [PW-1:0] CAP_ONE  = 5'h01;
  // sixteen ticks of the baud clock per bit
  localparam logic [3:0]  T_LAST   = 4'hf;
  localparam logic [3:0]  T_MID    = 4'h7;
  localparam logic [5:0]  T_BIT    = 6'h0f;
  localparam logic [5:0]  T_STOP1  = 6'h0f;
  localparam logic [5:0]  T_STOP15 = 6'h17;
  localparam logic [5:0]  T_STOP2  = 6'h1f;
  localparam logic [2:0]  MIN_LAST = 3'h4;
  localparam logic [15:0] DIV_RST  = 16'h0001;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ulmc_bus_t;

  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } ulmc_rxent_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulmc_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} ulmc_rx_st_t;

  typedef struct packed {
    logic [7:0]                 lfc;
    logic [4:0]                 moc;
    logic [3:0]                 ien;
    logic [15:0]                div;
    logic                       fen;
    logic [15:0]                bcnt;
    logic                       tick;
    logic [DEPTH-1:0][7:0]      txm;
    logic [PW-1:0]              txw;
    logic [PW-1:0]              txr;
    ulmc_tx_st_t                txs;
    logic [7:0]                 txsh;
    logic [2:0]                 txn;
    logic [5:0]                 txt;
    logic                       txbit;
    logic                       txpar;
    ulmc_rx_st_t                rxs;
    logic [7:0]                 rxsh;
    logic [2:0]                 rxn;
    logic [3:0]                 rxt;
    logic                       rxperr;
    logic                       rxz;
    ulmc_rxent_t [DEPTH-1:0]    rxm;
    logic [PW-1:0]              rxw;
    logic [PW-1:0]              rxr;
    logic                       oe;
    logic [2:0]                 err;
    logic [3:0]                 mlvl;
    logic [3:0]                 mdel;
    logic                       txd;
    logic                       trdy_n;
    logic                       rts_n;
    logic                       irq;
    logic                       irq_oe;
    logic [7:0]                 rdata;
  } ulmc_state_t;

  // index of the last data bit: 4 for five bits up to 7 for eight
  function automatic logic [2:0] ulmc_last(input logic [7:0] lfc);
    return MIN_LAST + {1'b0, lfc[1:0]};
  endfunction : ulmc_last

  // parity bit to send or expect, stick parity included
  function automatic logic ulmc_par(input logic [7:0] lfc, input logic [7:0] data);
    logic [7:0] m;
    m = data & (8'hff >> (3'h7 - ulmc_last(lfc)));
    if (lfc[LF_STICK]) return ~lfc[LF_EVEN];
    return lfc[LF_EVEN] ? ^m : ~^m;
  endfunction : ulmc_par
endpackage : ulmc_pkg

// ==== ulmc_modem_model.sv ====
// ulmc_modem_model: far-side data set; decodes txd frames, drives rxd and modem lines.
// assumes the divisor stays 1, so one bit lasts 16 clocks.
`timescale 1ns/1ps
`default_nettype none
module ulmc_modem_model (
  input  wire logic       clk_i,
  input  wire logic       txd_i,
  input  wire logic [3:0] nbits_i,
  output logic            rxd_o,
  output logic [3:0]      mdm_n_o
);
  logic [11:0] frame_q;
  int          frames_q;
  int          gap_q;
  int          gap_n;

  initial begin
    rxd_o = 1'b1;
    mdm_n_o = 4'hf;
    frames_q = 0;
  end

  // start confirmed, then data, parity and first stop sampled near mid-bit
  always begin
    do @(posedge clk_i); while (txd_i !== 1'b0);
    repeat (8) @(posedge clk_i);
    if (txd_i === 1'b0) begin
      frame_q = '0;
      for (int i = 0; i < nbits_i; i++) begin
        repeat (16) @(posedge clk_i);
        frame_q[i] = txd_i;
      end
      frames_q++;
      // mark time up to the next start gives the stop length
      // gap_q only moves when a gap ends, so it outlives the frame that follows
      gap_n = 0;
      while (txd_i === 1'b1 && gap_n < 100) begin
        @(posedge clk_i);
        gap_n++;
      end
      gap_q = gap_n;
    end
  end

  // start bit, then bits lsb first, then back to mark
  task automatic send(input logic [11:0] f, input int n);
    rxd_o <= 1'b0;
    repeat (16) @(posedge clk_i);
    for (int k = 0; k < n; k++) begin
      rxd_o <= f[k];
      repeat (16) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask : send

  task automatic set_lines(input logic r, input logic [3:0] m);
    rxd_o <= r;
    mdm_n_o <= m;
  endtask : set_lines
endmodule : ulmc_modem_model
`default_nettype wire

// ==== ulmc_core_test.sv ====
// ulmc_core_test: self-checking bench for the line format, modem control and status block.
// assumes divisor left at 1 and the modem model on the serial and handshake pins.
`timescale 1ns/1ps
`default_nettype none
module ulmc_core_test
  import ulmc_pkg::*;
;
  logic       clk;
  logic       reset_i;
  ulmc_bus_t  bus;
  logic [7:0] rdata;
  logic       txd;
  logic       rxd;
  logic       trdy_n;
  logic       rts_n;
  logic       irq;
  logic       irq_oe;
  logic [3:0] mdm_n;
  logic [3:0] nbits;
  logic [7:0] lfc;
  logic [7:0] d;
  logic [7:0] d2;
  int         n;
  int         f0;
  int         err_total;
  int         tests_run;

  ulmc_core uut (
    .clk_i               (clk),
    .reset_i             (reset_i),
    .bus_i               (bus),
    .rdata_o             (rdata),
    .rxd_i               (rxd),
    .txd_o               (txd),
    .clear_to_send_n_i   (mdm_n[0]),
    .data_set_ready_n_i  (mdm_n[1]),
    .ring_indicator_n_i  (mdm_n[2]),
    .carrier_detect_n_i  (mdm_n[3]),
    .terminal_ready_n_o  (trdy_n),
    .request_to_send_n_o (rts_n),
    .irq_o               (irq),
    .irq_oe_o            (irq_oe)
  );

  ulmc_modem_model mdl (
    .clk_i   (clk),
    .txd_i   (txd),
    .nbits_i (nbits),
    .rxd_o   (rxd),
    .mdm_n_o (mdm_n)
  );

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
    logic [7:0] v;
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
    chk(s, e, v & m);
  endtask : rc

  task automatic wait_frames(input int t);
    for (int k = 0; k < 2000 && mdl.frames_q < t; k++) @(posedge clk);
    chk("frames", 1, mdl.frames_q >= t);
  endtask : wait_frames

  // frame bits after the start: data, parity when enabled, one stop
  function automatic logic [11:0] mkf(input logic [7:0] f, input logic [7:0] v, input logic bp, input logic bs);
    logic [11:0] x;
    int          w;
    w = 5 + f[1:0];
    x = {4'h0, v} & ((12'h001 << w) - 12'h001);
    if (f[3]) x[w] = (f[5] ? ~f[4] : (f[4] ? ^x : ~^x)) ^ bp;
    x[w + f[3]] = ~bs;
    return x;
  endfunction : mkf

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    reset_i = 1'b1;
    bus = '0;
    nbits = 4'ha;
    err_total = 0;
    tests_run = 0;
    void'($urandom(53));
    repeat (8) @(posedge clk);
    reset_i <= 1'b0;
    #1 chk("pins", 4'he, {txd, trdy_n, rts_n, irq_oe});
    rc(3'h3, 8'hff, 8'h00, "fmt");
    rc(3'h5, 8'hff, 8'h60, "flags");
    rc(3'h7, 8'hff, 8'h00, "unmapped");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hef : 8'($urandom) & 8'hef;
      wr(3'h4, d);
      @(posedge clk);
      #1 chk("mctl pins", {~d[0], ~d[1], d[3]}, {trdy_n, rts_n, irq_oe});
      rc(3'h4, 8'hff, d & 8'h0f, "mctl");
    end
    wr(3'h4, 8'h08);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h01);
    rc(3'h0, 8'hff, 8'h01, "div low");
    rc(3'h5, 8'hff, 8'h60, "dsel flags");
    for (int i = 0; i < 8; i++) begin
      lfc = (8'($urandom) & 8'h34) | 8'(i & 3) | (i > 3 ? 8'h08 : 8'h00);
      d = 8'($urandom);
      d2 = 8'($urandom);
      nbits = 4'(6 + lfc[1:0] + lfc[3]);
      wr(3'h3, lfc);
      f0 = mdl.frames_q;
      wr(3'h0, d);
      rc(3'h5, 8'h60, 8'h20, "busy");
      wr(3'h0, d2);
      wait_frames(f0 + 1);
      chk("tx frame", mkf(lfc, d, 1'b0, 1'b0), mdl.frame_q);
      wait_frames(f0 + 2);
      chk("tx frame2", mkf(lfc, d2, 1'b0, 1'b0), mdl.frame_q);
      n = lfc[2] ? ((lfc[1:0] == 2'b00) ? 24 : 32) : 16;
      chk("stop len", 1, mdl.gap_q >= n - 11 && mdl.gap_q <= n - 5);
      repeat (40) @(posedge clk);
      rc(3'h5, 8'h60, 8'h60, "idle");
    end
    wr(3'h3, 8'h43);
    wr(3'h0, 8'h55);
    n = 0;
    repeat (200) @(posedge clk) n += (txd !== 1'b0);
    chk("brk txd", 0, 12'(n));
    wr(3'h3, 8'h03);
    repeat (300) @(posedge clk);
    chk("mark", 1, txd);
    wr(3'h1, 8'h04);
    for (int i = 0; i < 4; i++) begin
      lfc = 8'h08 | 8'(i << 4) | 8'(i) | (8'($urandom) & 8'h04);
      d = 8'($urandom);
      wr(3'h3, lfc);
      n = 6 + i + 1;
      mdl.send(mkf(lfc, d, 1'b0, 1'b0), n);
      #1 chk("irq quiet", 0, irq);
      rc(3'h5, 8'h1f, 8'h01, "rx flags");
      rc(3'h0, 8'hff, d & (8'hff >> (3 - i)), "rx data");
      rc(3'h5, 8'h01, 8'h00, "rx empty");
      mdl.send(mkf(lfc, d, 1'b1, 1'b0), n);
      #1 chk("irq", 1, irq);
      rc(3'h5, 8'h9f, 8'h05, "par err");
      rc(3'h5, 8'h1e, 8'h00, "err clr");
      rc(3'h0, 8'h00, 8'h00, "drain");
    end
    wr(3'h3, 8'h03);
    mdl.send(mkf(8'h03, 8'h3c, 1'b0, 1'b1), 9);
    rc(3'h5, 8'h0f, 8'h09, "frame err");
    rc(3'h0, 8'hff, 8'h3c, "fe data");
    repeat (200) @(posedge clk);
    rc(3'h5, 8'h1f, 8'h01, "resync");
    rc(3'h0, 8'hff, 8'hff, "resync data");
    d = 8'($urandom);
    d2 = 8'($urandom);
    mdl.send({4'h1, d}, 9);
    mdl.send({4'h1, d2}, 9);
    rc(3'h5, 8'h1f, 8'h03, "overrun");
    rc(3'h0, 8'hff, d2, "ovr data");
    rc(3'h5, 8'h1f, 8'h00, "ovr clr");
    mdl.send(12'h000, 12);
    rc(3'h5, 8'h11, 8'h11, "break");
    rc(3'h0, 8'hff, 8'h00, "brk data");
    rc(3'h5, 8'h01, 8'h00, "one zero");
    // the line must idle high for half a bit before a new start counts
    repeat (16) @(posedge clk);
    mdl.send({4'h1, 8'ha5}, 9);
    rc(3'h0, 8'hff, 8'ha5, "restart");
    wr(3'h4, 8'h15);
    mdl.set_lines(1'b0, 4'h0);
    repeat (2) @(posedge clk);
    #1 chk("loop pins", 4'he, {txd, trdy_n, rts_n, irq_oe});
    rc(3'h6, 8'hf0, 8'h60, "loop stat");
    f0 = mdl.frames_q;
    wr(3'h0, 8'h5a);
    repeat (200) @(posedge clk);
    rc(3'h0, 8'hff, 8'h5a, "loop data");
    chk("no frame", 12'(f0), 12'(mdl.frames_q));
    mdl.set_lines(1'b1, 4'h5);
    wr(3'h4, 8'h08);
    rc(3'h6, 8'hf0, 8'ha0, "levels");
    wr(3'h2, 8'h01);
    wr(3'h3, 8'h1b);
    nbits = 4'ha;
    f0 = mdl.frames_q;
    wr(3'h0, d);
    wr(3'h0, d2);
    // a third byte only survives when the transmit side queues
    wr(3'h0, 8'h3c);
    wait_frames(f0 + 3);
    chk("fifo tx", mkf(8'h1b, 8'h3c, 1'b0, 1'b0), mdl.frame_q);
    mdl.send(mkf(8'h1b, d, 1'b0, 1'b0), 10);
    mdl.send(mkf(8'h1b, d2, 1'b1, 1'b0), 10);
    rc(3'h5, 8'h9f, 8'h81, "fifo flags");
    rc(3'h0, 8'hff, d, "fifo data");
    rc(3'h5, 8'h9f, 8'h85, "fifo par");
    rc(3'h0, 8'hff, d2, "fifo data2");
    rc(3'h5, 8'h9f, 8'h00, "fifo clr");
    finish_test();
  end
endmodule : ulmc_core_test
`default_nettype wire
